// file: rtl/pads_top.sv
`timescale 1ns/10ps
module pads_top #(
	parameter int TICK_CYC = pads_pkg::TICK_CYC,
	parameter int STR_MAX = pads_pkg::STR_MAX
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Register port
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wr_data_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rd_data_out,
	// Line side
	output logic off_hook_out,
	output logic [1:0] line_state_out
);
	pads_pkg::pads_state_t state_r;
	pads_pkg::pads_state_t state_nxt;
	logic enabled_r;
	logic fast_r;
	logic first_r;
	logic gap_pend_r;
	logic [3:0] pulses_r;
	logic tm_load_r;
	logic [pads_pkg::TW-1:0] tm_ticks_r;
	logic off_hook_r;
	logic [1:0] line_state_r;
	logic [31:0] rd_data_r;
	logic tm_done;
	logic [7:0] st_ch;
	logic st_empty;
	logic [pads_pkg::CNT_W-1:0] st_cnt;
	logic st_clr;
	logic st_wr;
	logic st_adv;
	logic wr_ctrl;
	logic wr_str;
	logic busy;
	logic go;
	logic hang;
	logic [7:0] cmd;

	// Digit test
	function automatic logic is_digit(input logic [7:0] ch);
		return (ch >= pads_pkg::CH_ZERO) && (ch <= pads_pkg::CH_NINE);
	endfunction

	// Pulses for one digit
	function automatic logic [3:0] digit_pulses(input logic [7:0] ch);
		return (ch == pads_pkg::CH_ZERO) ? pads_pkg::ZERO_PULSES : ch[3:0];
	endfunction

	// Timer span on entry to a state
	function automatic logic [pads_pkg::TW-1:0] state_ticks(
		input pads_pkg::pads_state_t s, input logic f);
		case (s)
			pads_pkg::S_BREAK: return pads_pkg::BREAK_T;
			pads_pkg::S_SETTLE: return pads_pkg::SETTLE_T;
			pads_pkg::S_PULSE: return f ? pads_pkg::FAST_PULSE_T : pads_pkg::SLOW_PULSE_T;
			pads_pkg::S_GAP: return f ? pads_pkg::FAST_GAP_T : pads_pkg::SLOW_GAP_T;
			pads_pkg::S_DGAP: return f ? pads_pkg::FAST_DIG_T : pads_pkg::SLOW_DIG_T;
			pads_pkg::S_PAUSE: return pads_pkg::DELAY_T;
			pads_pkg::S_TRY: return pads_pkg::TRY_T;
			default: return '0;
		endcase
	endfunction

	// Line state code for a state
	function automatic logic [1:0] state_code(input pads_pkg::pads_state_t s);
		case (s)
			pads_pkg::S_IDLE: return pads_pkg::LS_IDLE;
			pads_pkg::S_TRY: return pads_pkg::LS_TRYING;
			pads_pkg::S_CONN: return pads_pkg::LS_CONNECTED;
			default: return pads_pkg::LS_DIALING;
		endcase
	endfunction

	// Register write decode
	always_comb begin
		wr_ctrl = 1'b0;
		wr_str = 1'b0;
		if (wr_in && addr_in == pads_pkg::REG_CTRL) begin
			wr_ctrl = 1'b1;
		end else if (wr_in && addr_in == pads_pkg::REG_DATA) begin
			wr_str = 1'b1;
		end
	end

	// Command qualifiers
	assign cmd = wr_data_in[7:0];
	assign busy = (state_r != pads_pkg::S_IDLE) && (state_r != pads_pkg::S_CONN);
	assign go = wr_ctrl && cmd == pads_pkg::CMD_CONNECT && !busy;
	assign hang = wr_ctrl && cmd == pads_pkg::CMD_HANGUP;
	assign st_clr = wr_ctrl && cmd == pads_pkg::CMD_ENABLE && !busy;
	assign st_wr = wr_str && enabled_r && !busy;
	assign st_adv = (state_r == pads_pkg::S_DECODE);

	// Number string store
	pads_store #(
		.DEPTH(STR_MAX),
		.W(8),
		.CW(pads_pkg::CNT_W)
	) u_store (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.clr_in(st_clr),
		.wr_in(st_wr),
		.wr_data_in(wr_data_in[7:0]),
		.adv_in(st_adv),
		.rd_data_out(st_ch),
		.empty_out(st_empty),
		.count_out(st_cnt)
	);

	// Dial timer
	pads_timer #(
		.TICK_CYC(TICK_CYC),
		.TW(pads_pkg::TW)
	) u_timer (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.load_in(tm_load_r),
		.ticks_in(tm_ticks_r),
		.done_out(tm_done)
	);

	// Sequencer next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			pads_pkg::S_IDLE, pads_pkg::S_CONN: begin
				if (go) begin
					state_nxt = enabled_r ? pads_pkg::S_BREAK : pads_pkg::S_TRY;
				end
			end
			pads_pkg::S_BREAK: begin
				if (tm_done) begin
					state_nxt = pads_pkg::S_SETTLE;
				end
			end
			pads_pkg::S_SETTLE: begin
				if (tm_done) begin
					state_nxt = pads_pkg::S_FETCH;
				end
			end
			pads_pkg::S_FETCH: begin
				state_nxt = st_empty ? pads_pkg::S_TRY : pads_pkg::S_DECODE;
			end
			pads_pkg::S_DECODE: begin
				if (is_digit(st_ch)) begin
					state_nxt = gap_pend_r ? pads_pkg::S_DGAP : pads_pkg::S_PULSE;
				end else if (st_ch == pads_pkg::CH_DELAY) begin
					state_nxt = pads_pkg::S_PAUSE;
				end else begin
					state_nxt = pads_pkg::S_FETCH;
				end
			end
			pads_pkg::S_DGAP: begin
				if (tm_done) begin
					state_nxt = pads_pkg::S_PULSE;
				end
			end
			pads_pkg::S_PULSE: begin
				if (tm_done) begin
					state_nxt = (pulses_r > 4'h1) ? pads_pkg::S_GAP : pads_pkg::S_FETCH;
				end
			end
			pads_pkg::S_GAP: begin
				if (tm_done) begin
					state_nxt = pads_pkg::S_PULSE;
				end
			end
			pads_pkg::S_PAUSE: begin
				if (tm_done) begin
					state_nxt = pads_pkg::S_FETCH;
				end
			end
			pads_pkg::S_TRY: begin
				if (tm_done) begin
					state_nxt = pads_pkg::S_CONN;
				end
			end
			default: begin
				state_nxt = pads_pkg::S_IDLE;
			end
		endcase
		if (hang) begin
			state_nxt = pads_pkg::S_IDLE;
		end
	end

	// State register
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			state_r <= pads_pkg::S_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Timer load on every entry to a timed state
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			tm_load_r <= 1'b0;
			tm_ticks_r <= '0;
		end else begin
			tm_load_r <= (state_nxt != state_r) && (state_ticks(state_nxt, fast_r) != '0);
			tm_ticks_r <= state_ticks(state_nxt, fast_r);
		end
	end

	// Dialer enable, cleared only by reset or hang up
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || hang) begin
			enabled_r <= 1'b0;
		end else if (st_clr) begin
			enabled_r <= 1'b1;
		end
	end

	// Rate select from the first string position
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || (go && enabled_r)) begin
			fast_r <= 1'b0;
			first_r <= 1'b1;
		end else if (state_r == pads_pkg::S_DECODE) begin
			first_r <= 1'b0;
			if (first_r && st_ch == pads_pkg::CH_FAST) begin
				fast_r <= 1'b1;
			end
		end
	end

	// Pulse count for the current digit
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			pulses_r <= '0;
		end else if (state_r == pads_pkg::S_DECODE && is_digit(st_ch)) begin
			pulses_r <= digit_pulses(st_ch);
		end else if (state_r == pads_pkg::S_PULSE && tm_done) begin
			pulses_r <= pulses_r - 4'h1;
		end
	end

	// Digit gap owed after a digit's last pulse
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || go || state_r == pads_pkg::S_DGAP) begin
			gap_pend_r <= 1'b0;
		end else if (state_r == pads_pkg::S_PULSE && tm_done && pulses_r == 4'h1) begin
			gap_pend_r <= 1'b1;
		end
	end

	// Hook: on-hook when idle, breaking or pulsing
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			off_hook_r <= 1'b0;
		end else begin
			off_hook_r <= !(state_nxt == pads_pkg::S_IDLE || state_nxt == pads_pkg::S_BREAK
				|| state_nxt == pads_pkg::S_PULSE);
		end
	end

	// Line state code
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			line_state_r <= pads_pkg::LS_IDLE;
		end else begin
			line_state_r <= state_code(state_nxt);
		end
	end

	// Read data, valid only the cycle after the strobe
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || !rd_in) begin
			rd_data_r <= '0;
		end else if (addr_in == pads_pkg::REG_CTRL) begin
			rd_data_r <= {30'h0, line_state_r};
		end else if (addr_in == pads_pkg::REG_STATUS) begin
			rd_data_r <= '0;
			rd_data_r[pads_pkg::ST_STATE_LSB +: 2] <= line_state_r;
			rd_data_r[pads_pkg::ST_EN_BIT] <= enabled_r;
			rd_data_r[pads_pkg::ST_FAST_BIT] <= fast_r;
			rd_data_r[pads_pkg::ST_BUSY_BIT] <= busy;
			rd_data_r[pads_pkg::ST_CNT_LSB +: pads_pkg::CNT_W] <= st_cnt;
		end else begin
			rd_data_r <= '0;
		end
	end

	// Outputs
	assign rd_data_out = rd_data_r;
	assign off_hook_out = off_hook_r;
	assign line_state_out = line_state_r;

	// Checks
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	AST_FAST_SEL: assert property (
		(state_r == pads_pkg::S_DECODE && first_r && st_ch == pads_pkg::CH_FAST)
		|=> fast_r)
		else $error("fast marker did not select fast rate");

	AST_SLOW_DEFAULT: assert property (
		(state_r == pads_pkg::S_BREAK) |-> !fast_r)
		else $error("dial rate not slow at start");

	AST_PAUSE: assert property (
		(state_r == pads_pkg::S_DECODE && st_ch == pads_pkg::CH_DELAY && !hang)
		|=> state_r == pads_pkg::S_PAUSE && tm_load_r && tm_ticks_r == pads_pkg::DELAY_T)
		else $error("delay character did not start a one second pause");

	AST_SKIP: assert property (
		(state_r == pads_pkg::S_DECODE && !is_digit(st_ch)
		&& st_ch != pads_pkg::CH_DELAY && !hang)
		|=> state_r == pads_pkg::S_FETCH && off_hook_r && !tm_load_r)
		else $error("unknown character caused output or delay");

	AST_LATE_FAST: assert property (
		(state_r == pads_pkg::S_DECODE && !first_r) |=> $stable(fast_r))
		else $error("late fast marker changed the rate");

	AST_STORE_MAX: assert property (
		st_cnt <= pads_pkg::CNT_W'(STR_MAX))
		else $error("store exceeded its capacity");

	AST_ENABLE_QUIET: assert property (
		st_clr |=> $stable(off_hook_r) && $stable(line_state_r) && enabled_r)
		else $error("enable command acted on the line");

	AST_BREAK_START: assert property (
		(go && enabled_r) |=> !off_hook_r && tm_ticks_r == pads_pkg::BREAK_T)
		else $error("connect did not break the line for two seconds");

	AST_BREAK_END: assert property (
		(state_r == pads_pkg::S_BREAK && tm_done && !hang)
		|=> off_hook_r && state_r == pads_pkg::S_SETTLE
		&& tm_ticks_r == pads_pkg::SETTLE_T)
		else $error("no reconnect and 500 ms wait after break");

	AST_ORDER: assert property (
		(state_r == pads_pkg::S_FETCH && !st_empty && !hang)
		|=> state_r == pads_pkg::S_DECODE ##1 state_r != pads_pkg::S_DECODE)
		else $error("character not taken singly");

	AST_PULSE_LEN: assert property (
		$rose(state_r == pads_pkg::S_PULSE) |-> !off_hook_r && tm_ticks_r ==
		(fast_r ? pads_pkg::FAST_PULSE_T : pads_pkg::SLOW_PULSE_T))
		else $error("wrong pulse length");

	AST_GAP_LEN: assert property (
		(state_r == pads_pkg::S_GAP && tm_load_r) |-> off_hook_r && tm_ticks_r ==
		(fast_r ? pads_pkg::FAST_GAP_T : pads_pkg::SLOW_GAP_T))
		else $error("wrong pulse gap");

	AST_ZERO_TEN: assert property (
		(state_r == pads_pkg::S_DECODE && st_ch == pads_pkg::CH_ZERO && !hang)
		|=> pulses_r == pads_pkg::ZERO_PULSES)
		else $error("zero did not give ten pulses");

	AST_DIGIT_GAP: assert property (
		(state_r == pads_pkg::S_DGAP && tm_load_r) |-> off_hook_r && tm_ticks_r ==
		(fast_r ? pads_pkg::FAST_DIG_T : pads_pkg::SLOW_DIG_T) && $past(gap_pend_r))
		else $error("wrong digit gap");

	AST_DIRECT: assert property (
		(go && !enabled_r) |=> state_r == pads_pkg::S_TRY && off_hook_r)
		else $error("direct connect did not go off hook");

	AST_STATE_CODE: assert property (
		(state_r == pads_pkg::S_PULSE || state_r == pads_pkg::S_DGAP)
		|-> line_state_r == pads_pkg::LS_DIALING)
		else $error("line state not dialing");

	AST_CONN_CODE: assert property (
		(state_r == pads_pkg::S_TRY && tm_done && !hang)
		|=> line_state_r == pads_pkg::LS_CONNECTED)
		else $error("line state not connected");

	CVR_FAST_PULSE: cover property ($rose(state_r == pads_pkg::S_PULSE) && fast_r);
	CVR_PAUSE: cover property (state_r == pads_pkg::S_PAUSE && tm_done);
	CVR_DIRECT: cover property (go && !enabled_r);
	CVR_DIALED: cover property ($rose(state_r == pads_pkg::S_CONN) && enabled_r);

endmodule // pads_top

// file: rtl/pads_pkg.sv
package pads_pkg;

	// Register offsets on the plain register port
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_DATA = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;

	// Control codes written to the control register
	localparam logic [7:0] CMD_HANGUP = 8'h00;
	localparam logic [7:0] CMD_CONNECT = 8'h01;
	localparam logic [7:0] CMD_ENABLE = 8'h02;

	// Characters the dialer recognises
	localparam logic [7:0] CH_FAST = 8'h3E;
	localparam logic [7:0] CH_DELAY = 8'h40;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [3:0] ZERO_PULSES = 4'hA;

	// Line state codes
	localparam logic [1:0] LS_IDLE = 2'h0;
	localparam logic [1:0] LS_TRYING = 2'h1;
	localparam logic [1:0] LS_DIALING = 2'h2;
	localparam logic [1:0] LS_CONNECTED = 2'h3;

	// Status register fields
	localparam int ST_STATE_LSB = 0;
	localparam int ST_EN_BIT = 2;
	localparam int ST_FAST_BIT = 3;
	localparam int ST_BUSY_BIT = 4;
	localparam int ST_CNT_LSB = 16;

	// Store size and clocking
	localparam int STR_MAX = 500;
	localparam int CNT_W = 9;
	localparam int CLK_NS = 20;
	localparam int TICK_US = 500;
	localparam int TICK_CYC = TICK_US * 1000 / CLK_NS;
	localparam int TW = 12;

	// Dialing times in microseconds
	localparam int SLOW_PULSE_US = 60000;
	localparam int SLOW_GAP_US = 40000;
	localparam int SLOW_DIG_US = 700000;
	localparam int FAST_PULSE_US = 32500;
	localparam int FAST_GAP_US = 17500;
	localparam int FAST_DIG_US = 300000;
	localparam int DELAY_US = 1000000;
	localparam int BREAK_US = 2000000;
	localparam int SETTLE_US = 500000;

	// Same times in timer ticks
	localparam logic [TW-1:0] SLOW_PULSE_T = TW'(SLOW_PULSE_US / TICK_US);
	localparam logic [TW-1:0] SLOW_GAP_T = TW'(SLOW_GAP_US / TICK_US);
	localparam logic [TW-1:0] SLOW_DIG_T = TW'(SLOW_DIG_US / TICK_US);
	localparam logic [TW-1:0] FAST_PULSE_T = TW'(FAST_PULSE_US / TICK_US);
	localparam logic [TW-1:0] FAST_GAP_T = TW'(FAST_GAP_US / TICK_US);
	localparam logic [TW-1:0] FAST_DIG_T = TW'(FAST_DIG_US / TICK_US);
	localparam logic [TW-1:0] DELAY_T = TW'(DELAY_US / TICK_US);
	localparam logic [TW-1:0] BREAK_T = TW'(BREAK_US / TICK_US);
	localparam logic [TW-1:0] SETTLE_T = TW'(SETTLE_US / TICK_US);
	localparam logic [TW-1:0] TRY_T = 12'h001;

	// Sequencer states, Gray steps from idle to the first pulse and between pulse and gap
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_BREAK = 4'h1,
		S_SETTLE = 4'h3,
		S_FETCH = 4'h2,
		S_DECODE = 4'h6,
		S_PULSE = 4'h7,
		S_GAP = 4'h5,
		S_DGAP = 4'h4,
		S_PAUSE = 4'hC,
		S_TRY = 4'hD,
		S_CONN = 4'hF
	} pads_state_t;

endpackage

// file: rtl/pads_store.sv
`timescale 1ns/10ps
module pads_store #(
	parameter int DEPTH = 500,
	parameter int W = 8,
	parameter int CW = 9
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Fill side
	input wire logic clr_in,
	input wire logic wr_in,
	input wire logic [W-1:0] wr_data_in,
	// Drain side
	input wire logic adv_in,
	output logic [W-1:0] rd_data_out,
	output logic empty_out,
	output logic [CW-1:0] count_out
);
	logic [W-1:0] mem [DEPTH];
	logic [CW-1:0] wr_ptr_r;
	logic [CW-1:0] rd_ptr_r;

	// Character array, writes past the end are dropped
	always_ff @(posedge ref_clk_in) begin
		if (wr_in && !clr_in && wr_ptr_r < CW'(DEPTH)) begin
			mem[wr_ptr_r] <= wr_data_in;
		end
	end

	// Write pointer
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || clr_in) begin
			wr_ptr_r <= '0;
		end else if (wr_in && wr_ptr_r < CW'(DEPTH)) begin
			wr_ptr_r <= wr_ptr_r + 1'b1;
		end
	end

	// Read pointer, strictly in arrival order
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || clr_in) begin
			rd_ptr_r <= '0;
		end else if (adv_in && rd_ptr_r != wr_ptr_r) begin
			rd_ptr_r <= rd_ptr_r + 1'b1;
		end
	end

	// Current character and fill state
	assign empty_out = (rd_ptr_r == wr_ptr_r);
	assign rd_data_out = empty_out ? '0 : mem[rd_ptr_r];
	assign count_out = wr_ptr_r;

endmodule // pads_store

// file: rtl/pads_timer.sv
`timescale 1ns/10ps
module pads_timer #(
	parameter int TICK_CYC = 25000,
	parameter int TW = 12
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Load and done
	input wire logic load_in,
	input wire logic [TW-1:0] ticks_in,
	output logic done_out
);
	localparam int DW = $clog2(TICK_CYC);
	logic [DW-1:0] div_r;
	logic [TW-1:0] cnt_r;

	// Tick divider, restarted on every load for exact spans
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || load_in || div_r == '0) begin
			div_r <= DW'(TICK_CYC - 1);
		end else begin
			div_r <= div_r - 1'b1;
		end
	end

	// Tick down counter
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			cnt_r <= '0;
		end else if (load_in) begin
			cnt_r <= ticks_in;
		end else if (div_r == '0 && cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

	// Done never shows in the load cycle
	assign done_out = (cnt_r == '0) && !load_in;

endmodule // pads_timer

// file: bench/pads_line_model.sv
`timescale 1ns/10ps
module pads_line_model (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Line loop level and measurement restart
	input wire logic off_hook_in,
	input wire logic mark_in
);
	int seg_q[$];
	int run_cnt;
	logic last_lvl;

	// Length in cycles of every closed or broken loop span, one entry per level change
	always @(posedge ref_clk_in) begin
		last_lvl <= off_hook_in;
		if (rst_in || mark_in) begin
			seg_q.delete();
			run_cnt <= 0;
		end else if (off_hook_in !== last_lvl) begin
			seg_q.push_back(run_cnt);
			run_cnt <= 1;
		end else begin
			run_cnt <= run_cnt + 1;
		end
	end
endmodule // pads_line_model

// file: bench/testbench.sv
`timescale 1ns/10ps
module testbench;
	localparam int T = 4;
	logic ref_clk_in = 1'h0;
	logic rst_in = 1'h1;
	logic [7:0] addr_in = 8'h00;
	logic [31:0] wr_data_in = 32'h0;
	logic wr_in = 1'h0;
	logic rd_in = 1'h0;
	logic mark = 1'h0;
	logic [31:0] rd_data_out;
	logic off_hook_out;
	logic [1:0] line_state_out;
	logic [31:0] got;
	int mismatches = 0;
	int cmp_count = 0;
	int n;

	// Free running clock
	always #10 ref_clk_in = ~ref_clk_in;

	// Sequencer with a short timer tick
	pads_top #(.TICK_CYC(T)) dut (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.addr_in(addr_in),
		.wr_data_in(wr_data_in),
		.wr_in(wr_in),
		.rd_in(rd_in),
		.rd_data_out(rd_data_out),
		.off_hook_out(off_hook_out),
		.line_state_out(line_state_out)
	);

	// Telephone line watching the loop
	pads_line_model line (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.off_hook_in(off_hook_out),
		.mark_in(mark)
	);

	// Counts, verdict and end of run
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Exact compare of one value
	task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Compare of one value against a closed range
	task automatic chk_rng(input logic [31:0] g, input int lo, input int hi);
		cmp_count++;
		if ((g >= lo && g <= hi) !== 1'h1) begin
			mismatches++;
			$display("ERROR at %0t: got %h expected %h to %h", $time, g, lo, hi);
		end
	endtask

	// Span length against a tick count, a little drift allowed for fetch steps
	task automatic chk_seg(input int i, input int ticks, input int slack);
		chk_rng(line.seg_q[i], ticks * T - 2, ticks * T + slack);
	endtask

	// Loop level and line state seen in the next settled cycle
	task automatic chk_line(input logic [2:0] e);
		@(negedge ref_clk_in);
		chk_val({29'h0, off_hook_out, line_state_out}, {29'h0, e});
		@(posedge ref_clk_in);
	endtask

	// One-cycle write; strobe stays up for a following write
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr_in <= a;
		wr_data_in <= {24'h0, d};
		rd_in <= 1'h0;
		wr_in <= 1'h1;
		@(posedge ref_clk_in);
	endtask

	// Strobes and span restart released for one cycle
	task automatic idle();
		wr_in <= 1'h0;
		rd_in <= 1'h0;
		mark <= 1'h0;
		@(posedge ref_clk_in);
	endtask

	// One-cycle read, data taken in the following cycle
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] q);
		addr_in <= a;
		wr_in <= 1'h0;
		rd_in <= 1'h1;
		@(posedge ref_clk_in);
		rd_in <= 1'h0;
		@(negedge ref_clk_in);
		q = rd_data_out;
		@(posedge ref_clk_in);
	endtask

	// Enable code, then the number string right behind it
	task automatic load(input string s);
		wr_reg(pads_pkg::REG_CTRL, pads_pkg::CMD_ENABLE);
		for (int i = 0; i < s.len(); i++)
			wr_reg(pads_pkg::REG_DATA, s[i]);
		idle();
	endtask

	// Start command with the span measurement restarted at the same edge
	task automatic go_connect();
		mark <= 1'h1;
		wr_reg(pads_pkg::REG_CTRL, pads_pkg::CMD_CONNECT);
		idle();
	endtask

	// Bounded wait for a line state, k counts the cycles spent
	task automatic wait_ls(input logic [1:0] v, input int bound, output int k);
		k = 0;
		@(negedge ref_clk_in);
		while (line_state_out !== v && k < bound) begin
			@(negedge ref_clk_in);
			k++;
		end
		if (k >= bound) begin
			mismatches++;
			$display("ERROR at %0t: got %h expected %h", $time, line_state_out, v);
			complete_run();
		end else begin
			@(posedge ref_clk_in);
		end
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge ref_clk_in);
		rst_in <= 1'h0;
		rd_reg(8'h0C, got);
		chk_val(got, 32'h0);
		rd_reg(pads_pkg::REG_DATA, got);
		chk_val(got, 32'h0);
		wr_reg(pads_pkg::REG_DATA, "5");
		idle();
		rd_reg(pads_pkg::REG_STATUS, got);
		chk_val(got, 32'h0);
		$display("test registers done");

		wr_reg(pads_pkg::REG_CTRL, pads_pkg::CMD_ENABLE);
		repeat (pads_pkg::STR_MAX + 1) wr_reg(pads_pkg::REG_DATA, "-");
		idle();
		rd_reg(pads_pkg::REG_STATUS, got);
		chk_val({23'h0, got[24:16]}, 32'(pads_pkg::STR_MAX));
		chk_val({29'h0, got[2:0]}, 32'h4);
		chk_line(3'h0);
		wr_reg(pads_pkg::REG_CTRL, pads_pkg::CMD_HANGUP);
		idle();
		$display("test store limit done");

		load("(2)-@>1");
		go_connect();
		chk_line({1'h0, pads_pkg::LS_DIALING});
		wait_ls(pads_pkg::LS_TRYING, 60000, n);
		chk_seg(0, pads_pkg::BREAK_T, 6);
		chk_seg(1, pads_pkg::SETTLE_T, 10);
		chk_seg(2, pads_pkg::SLOW_PULSE_T, 6);
		chk_seg(3, pads_pkg::SLOW_GAP_T, 6);
		chk_seg(4, pads_pkg::SLOW_PULSE_T, 6);
		chk_seg(5, pads_pkg::SLOW_DIG_T + pads_pkg::DELAY_T, 20);
		chk_seg(6, pads_pkg::SLOW_PULSE_T, 6);
		chk_val(line.seg_q.size(), 32'h7);
		wait_ls(pads_pkg::LS_CONNECTED, T + 4, n);
		chk_rng(n, T - 2, T + 4);
		rd_reg(pads_pkg::REG_CTRL, got);
		chk_val({30'h0, got[1:0]}, {30'h0, pads_pkg::LS_CONNECTED});
		chk_line({1'h1, pads_pkg::LS_CONNECTED});
		wr_reg(pads_pkg::REG_CTRL, pads_pkg::CMD_HANGUP);
		idle();
		chk_line(3'h0);
		$display("test slow dial done");

		load(">0 1");
		go_connect();
		rd_reg(pads_pkg::REG_STATUS, got);
		chk_val(got & 32'h13, 32'h12);
		wr_reg(pads_pkg::REG_CTRL, pads_pkg::CMD_CONNECT);
		idle();
		wait_ls(pads_pkg::LS_TRYING, 60000, n);
		chk_seg(0, pads_pkg::BREAK_T, 6);
		chk_seg(1, pads_pkg::SETTLE_T, 10);
		for (int i = 0; i < 10; i++)
			chk_seg(2 + 2 * i, pads_pkg::FAST_PULSE_T, 6);
		for (int i = 0; i < 9; i++)
			chk_seg(3 + 2 * i, pads_pkg::FAST_GAP_T, 6);
		chk_seg(21, pads_pkg::FAST_DIG_T, 10);
		chk_seg(22, pads_pkg::FAST_PULSE_T, 6);
		chk_val(line.seg_q.size(), 32'h17);
		wait_ls(pads_pkg::LS_CONNECTED, T + 4, n);
		chk_rng(n, T - 2, T + 4);
		$display("test fast dial done");

		wr_reg(pads_pkg::REG_CTRL, pads_pkg::CMD_HANGUP);
		idle();
		chk_line(3'h0);
		go_connect();
		chk_line({1'h1, pads_pkg::LS_TRYING});
		wait_ls(pads_pkg::LS_CONNECTED, T + 4, n);
		chk_val(line.seg_q.size(), 32'h1);
		chk_line({1'h1, pads_pkg::LS_CONNECTED});
		$display("test direct connect done");
		complete_run();
	end
endmodule // testbench
